/* File: alarm_log_pkg.sv */
// Purpose: Shared constants for the alarm event log.
// Assumes: One 20 MHz system clock, AXI4-Lite register access.
// Notes: All offsets are byte addresses of 32-bit words.
`default_nettype none
package alarm_log_pkg;
    localparam int unsigned EVENT_COUNT = 16;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CONFIRM_WINDOW_MS = 2000;
    localparam int unsigned CONFIRM_CYCLES = CLK_HZ / 1000 * CONFIRM_WINDOW_MS;
    localparam logic [7:0] OFF_FLAGS = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] OFF_VIEW = 8'h18;
    localparam logic [7:0] OFF_CURSOR = 8'h1C;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam int unsigned CTRL_CLEAR_BIT = 0;
    localparam int unsigned CTRL_OPTO_DIAG_BIT = 1;
    localparam int unsigned IRQ_NEW_EVENT_BIT = 0;
    localparam int unsigned IRQ_CLEARED_BIT = 1;
    localparam int unsigned IRQ_EXPIRED_BIT = 2;
    localparam logic [7:0] CHAR_DOT = 8'h2E;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

/* File: alarm_confirm_timer.sv */
// Purpose: Two-press confirmation window for the keypad clear.
// Assumes: Presses are one-cycle pulses synchronous to the clock.
// Notes: A press while the window is open confirms and closes it.
`default_nettype none
module alarm_confirm_timer #(
    parameter int unsigned WINDOW_CYCLES = alarm_log_pkg::CONFIRM_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Key pulse
    input wire logic press_in,
    // Results
    output logic open_out,
    output logic confirm_out,
    output logic expire_out
);
    logic [31:0] count_r;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            open_out <= 1'b0;
            count_r <= 32'h0000_0000;
            confirm_out <= 1'b0;
            expire_out <= 1'b0;
        end else begin
            confirm_out <= 1'b0;
            expire_out <= 1'b0;
            if (!open_out) begin
                if (press_in) begin
                    open_out <= 1'b1;
                    count_r <= 32'(WINDOW_CYCLES - 1);
                end
            end else if (press_in) begin
                open_out <= 1'b0;
                confirm_out <= 1'b1;
            end else if (count_r == 32'h0000_0000) begin
                open_out <= 1'b0;
                expire_out <= 1'b1;
            end else begin
                count_r <= count_r - 32'h0000_0001;
            end
        end
    end
endmodule // alarm_confirm_timer
`default_nettype wire

/* File: alarm_event_log.sv */
// Purpose: Sticky diagnostic alarm event log with mask, clear and status view.
// Assumes: Event conditions and keys are synchronous one-clock inputs.
// Notes: Registers are reached over AXI4-Lite; flags live in plain flops.
//
// Notes on behaviour
// - Sixteen event flags at fixed codes 0-15.
// - A set flag stays until whole-log clear.
// - Clear by confirmed keypad or host request.
// - Volatile: flags come up cleared after reset.
// - Masked events never set their flag.
// - Keypad clear needs second accept within two seconds.
// - View shows dot or code, 0 leftmost.
// - Mask edit: cursor at 0, down moves, up toggles.
// - List scrolls with up/down, accept/cancel leave.
// - Diagnostic optical output on while any flag set.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module alarm_event_log #(
    parameter int unsigned EVENTS = alarm_log_pkg::EVENT_COUNT,
    parameter int unsigned CONFIRM_CYCLES = alarm_log_pkg::CONFIRM_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Event conditions
    input wire logic [15:0] event_in,
    // Keypad pulses
    input wire logic key_accept_in,
    input wire logic key_cancel_in,
    input wire logic upper_key_in,
    input wire logic lower_key_in,
    // Keypad mode selects
    input wire logic mode_log_in,
    input wire logic mode_mask_in,
    input wire logic mode_list_in,
    // AXI4-Lite write
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Outputs
    output logic [15:0] flags_out,
    output logic [127:0] view_out,
    output logic opto_diag_out,
    output logic edit_active_out,
    output logic [3:0] cursor_out,
    output logic list_active_out,
    output logic [3:0] list_index_out,
    output logic confirm_open_out,
    output logic irq_out
);
    typedef enum logic [2:0] {
        UI_IDLE = 3'b001,
        UI_EDIT = 3'b010,
        UI_LIST = 3'b100
    } ui_state_type;

    ui_state_type ui_r;
    logic [15:0] mask_r;
    logic [15:0] edit_mask_r;
    logic [15:0] flags_r;
    logic opto_en_r;
    logic [2:0] irq_status_r;
    logic [2:0] irq_enable_r;
    logic host_clear_r;
    logic kp_press;
    logic kp_confirm;
    logic kp_expire;
    logic log_clear;
    logic [15:0] flags_nxt;
    logic [127:0] view_nxt;
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire;
    logic [2:0] irq_set;

    ////////////////////////////////////////////////////////////////////////////
    // Keypad clear confirmation.

    assign kp_press = key_accept_in && mode_log_in && (ui_r == UI_IDLE);

    alarm_confirm_timer #(
        .WINDOW_CYCLES(CONFIRM_CYCLES)
    ) u_confirm (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .press_in(kp_press),
        .open_out(confirm_open_out),
        .confirm_out(kp_confirm),
        .expire_out(kp_expire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event log.

    assign log_clear = kp_confirm || host_clear_r;
    // Clear wins over a same-cycle event; the event is lost if it is gone next cycle.
    assign flags_nxt = log_clear ? alarm_log_pkg::FLAGS_RESET
                                 : (flags_r | (event_in & ~mask_r));

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            flags_r <= alarm_log_pkg::FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Each position shows a dot or its hex code character, code 0 in the top byte.
    generate
        for (genvar i = 0; i < 16; i++) begin : g_view
            localparam logic [7:0] CODE_CHAR = (i < 10) ? 8'(8'h30 + i) : 8'(8'h37 + i);
            assign view_nxt[127 - 8*i -: 8] = flags_nxt[i] ? CODE_CHAR
                                                           : alarm_log_pkg::CHAR_DOT;
        end
    endgenerate

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            flags_out <= alarm_log_pkg::FLAGS_RESET;
            view_out <= {16{alarm_log_pkg::CHAR_DOT}};
            opto_diag_out <= 1'b0;
        end else begin
            flags_out <= flags_nxt;
            view_out <= view_nxt;
            opto_diag_out <= opto_en_r && (flags_nxt != 16'h0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Keypad mask editing and event list.

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ui_r <= UI_IDLE;
            edit_mask_r <= alarm_log_pkg::MASK_RESET;
            cursor_out <= 4'h0;
            list_index_out <= 4'h0;
        end else begin
            unique case (ui_r)
                UI_IDLE: begin
                    if (key_accept_in && mode_mask_in) begin
                        ui_r <= UI_EDIT;
                        cursor_out <= 4'h0;
                        edit_mask_r <= mask_r;
                    end else if (key_accept_in && mode_list_in) begin
                        ui_r <= UI_LIST;
                        list_index_out <= 4'h0;
                    end
                end
                UI_EDIT: begin
                    if (key_accept_in || key_cancel_in) begin
                        ui_r <= UI_IDLE;
                    end else if (lower_key_in) begin
                        cursor_out <= cursor_out + 4'h1;
                    end else if (upper_key_in) begin
                        edit_mask_r[cursor_out] <= ~edit_mask_r[cursor_out];
                    end
                end
                UI_LIST: begin
                    if (key_accept_in || key_cancel_in) begin
                        ui_r <= UI_IDLE;
                    end else if (lower_key_in) begin
                        list_index_out <= list_index_out + 4'h1;
                    end else if (upper_key_in) begin
                        list_index_out <= list_index_out - 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            edit_active_out <= 1'b0;
            list_active_out <= 1'b0;
        end else begin
            edit_active_out <= (ui_r == UI_EDIT) && !(key_accept_in || key_cancel_in)
                || (ui_r == UI_IDLE) && key_accept_in && mode_mask_in;
            list_active_out <= (ui_r == UI_LIST) && !(key_accept_in || key_cancel_in)
                || (ui_r == UI_IDLE) && key_accept_in && !mode_mask_in && mode_list_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.

    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= alarm_log_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r[1:0] == 2'b00 && aw_addr_r <= alarm_log_pkg::OFF_CURSOR)
                    ? alarm_log_pkg::RESP_OKAY : alarm_log_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; the mask is shared by keypad accept and host writes.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mask_r <= alarm_log_pkg::MASK_RESET;
            opto_en_r <= 1'b0;
            irq_enable_r <= 3'b000;
            host_clear_r <= 1'b0;
        end else begin
            host_clear_r <= 1'b0;
            if (ui_r == UI_EDIT && key_accept_in) begin
                mask_r <= edit_mask_r;
            end else if (wr_fire && aw_addr_r == alarm_log_pkg::OFF_MASK) begin
                if (w_strb_r[0]) mask_r[7:0] <= w_data_r[7:0];
                if (w_strb_r[1]) mask_r[15:8] <= w_data_r[15:8];
            end
            if (wr_fire && aw_addr_r == alarm_log_pkg::OFF_CTRL && w_strb_r[0]) begin
                host_clear_r <= w_data_r[alarm_log_pkg::CTRL_CLEAR_BIT];
                opto_en_r <= w_data_r[alarm_log_pkg::CTRL_OPTO_DIAG_BIT];
            end
            if (wr_fire && aw_addr_r == alarm_log_pkg::OFF_IRQ_ENABLE && w_strb_r[0]) begin
                irq_enable_r <= w_data_r[2:0];
            end
        end
    end

    // Interrupt status: set wins over a same-cycle write-one clear.
    assign irq_set[alarm_log_pkg::IRQ_NEW_EVENT_BIT] = !log_clear && (flags_nxt != flags_r);
    assign irq_set[alarm_log_pkg::IRQ_CLEARED_BIT] = log_clear;
    assign irq_set[alarm_log_pkg::IRQ_EXPIRED_BIT] = kp_expire;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            irq_status_r <= 3'b000;
            irq_out <= 1'b0;
        end else begin
            if (wr_fire && aw_addr_r == alarm_log_pkg::OFF_IRQ_CLEAR && w_strb_r[0]) begin
                irq_status_r <= (irq_status_r & ~w_data_r[2:0]) | irq_set;
            end else begin
                irq_status_r <= irq_status_r | irq_set;
            end
            irq_out <= |(irq_status_r & irq_enable_r);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= alarm_log_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= alarm_log_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    alarm_log_pkg::OFF_FLAGS: s_axi_rdata <= {16'h0000, flags_r};
                    alarm_log_pkg::OFF_MASK: s_axi_rdata <= {16'h0000, mask_r};
                    alarm_log_pkg::OFF_CTRL: s_axi_rdata <= {30'h0000_0000, opto_en_r, 1'b0};
                    alarm_log_pkg::OFF_IRQ_STATUS: s_axi_rdata <= {29'h0000_0000, irq_status_r};
                    alarm_log_pkg::OFF_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
                    alarm_log_pkg::OFF_IRQ_ENABLE: s_axi_rdata <= {29'h0000_0000, irq_enable_r};
                    alarm_log_pkg::OFF_VIEW: s_axi_rdata <= {16'h0000, edit_mask_r};
                    alarm_log_pkg::OFF_CURSOR: s_axi_rdata <= {16'h0000, list_index_out,
                        cursor_out, 5'h00, ui_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= alarm_log_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_sticky_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !log_clear |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
        else $error("Set flag dropped without clear.");
    a_mask_blocks: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (!$past(flags_r[0]) && $past(mask_r[0])) |-> !flags_r[0])
        else $error("Masked event was logged.");
    a_clear_wins: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        log_clear |=> flags_r == 16'h0000)
        else $error("Clear did not empty log.");
    a_event_logged: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (!log_clear && (event_in & ~mask_r) != 16'h0000) |=> flags_r != 16'h0000)
        else $error("Unmasked event not logged.");
    a_host_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_fire && aw_addr_r == alarm_log_pkg::OFF_CTRL && w_strb_r[0] && w_data_r[0])
        |-> ##2 flags_r == 16'h0000)
        else $error("Host clear missed.");
    a_opto_follow: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ($past(opto_en_r) && flags_r != 16'h0000) |-> opto_diag_out)
        else $error("Diagnostic output not energized.");
    a_view_dot: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !flags_out[0] |-> view_out[127:120] == alarm_log_pkg::CHAR_DOT)
        else $error("Inactive event not shown as dot.");
    a_edit_cursor: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (ui_r == UI_IDLE && key_accept_in && mode_mask_in) |=> cursor_out == 4'h0)
        else $error("Cursor not at position zero.");
    a_list_exit: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (ui_r == UI_LIST && key_cancel_in) |=> ui_r == UI_IDLE)
        else $error("List mode not left.");
    a_single_press: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (kp_press && !confirm_open_out) |=> !kp_confirm)
        else $error("Single press cleared log.");

    c_kp_clear: cover property (@(posedge sys_clk_in) kp_confirm);
    c_kp_expire: cover property (@(posedge sys_clk_in) kp_expire);
    c_mask_store: cover property (@(posedge sys_clk_in) ui_r == UI_EDIT && key_accept_in);
    c_irq: cover property (@(posedge sys_clk_in) irq_out);
endmodule // alarm_event_log
`default_nettype wire

/* File: keypad_user_model.sv */
// Purpose: Keypad user who presses keys and picks menus for the alarm log.
// Assumes: Each press is a one-cycle pulse launched right after a rising edge.
// Notes: Host traffic is played by the bench's register tasks, not here.
`default_nettype none
module keypad_user_model (
    // Clock
    input wire logic sys_clk_in,
    // Keys and menu selects
    output logic [3:0] key_out,
    output logic [2:0] mode_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        key_out = 4'h0;
        mode_out = 3'h0;
    end
    // Key order is accept, cancel, up, down; a released key goes back low.
    task automatic press(input int k);
        @(posedge sys_clk_in);
        key_out <= 4'h1 << k;
        @(posedge sys_clk_in);
        key_out <= 4'h0;
    endtask
    // Menu order is log, mask, list; the choice stays until changed.
    task automatic pick(input int m);
        @(posedge sys_clk_in);
        mode_out <= 3'h1 << m;
    endtask
endmodule // keypad_user_model
`default_nettype wire

/* File: alarm_event_log_test.sv */
// Purpose: Self-checking bench for the alarm event log.
// Assumes: Confirm window shortened to 20 cycles.
// Notes: Integer copies of flags and mask predict the flag, view, opto and mask results.
`default_nettype none
module alarm_event_log_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WIN = 20;
    logic sys_clk_in;
    logic sys_rst_in;
    logic [15:0] event_in;
    wire logic key_accept_in, key_cancel_in, upper_key_in, lower_key_in;
    wire logic mode_log_in, mode_mask_in, mode_list_in;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb, wr_strb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [15:0] flags_out;
    logic [127:0] view_out;
    logic opto_diag_out, edit_active_out, list_active_out, confirm_open_out, irq_out;
    logic [3:0] cursor_out, list_index_out, idx;
    int fails = 0, cmp_count = 0, log_m = 0, mask_m = 0, opto_en = 0, nm = 0, st = 0;

    alarm_event_log #(.CONFIRM_CYCLES(WIN)) dut (
        .sys_clk_in, .sys_rst_in, .event_in, .key_accept_in, .key_cancel_in,
        .upper_key_in, .lower_key_in, .mode_log_in, .mode_mask_in, .mode_list_in,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .flags_out, .view_out, .opto_diag_out,
        .edit_active_out, .cursor_out, .list_active_out, .list_index_out,
        .confirm_open_out, .irq_out
    );
    keypad_user_model pad (
        .sys_clk_in(sys_clk_in),
        .key_out({lower_key_in, upper_key_in, key_cancel_in, key_accept_in}),
        .mode_out({mode_list_in, mode_mask_in, mode_log_in})
    );
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= wr_strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    // A code shows as its hex digit, an idle code as a dot, code 0 leftmost.
    function automatic logic [127:0] view_of(input int f);
        logic [127:0] v;
        for (int i = 0; i < 16; i++) begin
            v[127 - 8 * i -: 8] = f[i] ? ((i < 10) ? 8'h30 + 8'(i) : 8'h37 + 8'(i))
                                       : alarm_log_pkg::CHAR_DOT;
        end
        return v;
    endfunction
    task automatic fire(input logic [15:0] ev);
        @(posedge sys_clk_in);
        event_in <= ev;
        @(posedge sys_clk_in);
        event_in <= 16'h0000;
        log_m = log_m | (ev & ~mask_m[15:0]);
        repeat (4) @(posedge sys_clk_in);
    endtask
    task automatic check_log();
        rd_reg(alarm_log_pkg::OFF_FLAGS);
        check("flags reg", rd, log_m);
        check("flags port", flags_out, log_m);
        check("view", view_out, view_of(log_m));
        check("opto", opto_diag_out, opto_en != 0 && log_m != 0);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        fails++;
        report_and_stop();
    end
    //////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst_in <= 1'b1;
        event_in <= 16'h0000;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        s_axi_awaddr <= 8'h00;
        s_axi_araddr <= 8'h00;
        s_axi_wdata <= 32'h0000_0000;
        s_axi_wstrb <= 4'h0;
        wr_strb = 4'hf;
        void'($urandom(32'h3f47_b8cf));
        repeat (6) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        check_log();
        rd_reg(alarm_log_pkg::OFF_MASK);
        check("mask reset", rd, alarm_log_pkg::MASK_RESET);
        $display("test reset done");
        wr(alarm_log_pkg::OFF_CTRL, 32'h0000_0002);
        opto_en = 1;
        for (int r = 0; r < 6; r++) begin
            // Random byte strobes: only the enabled mask bytes may change.
            st = $urandom;
            nm = $urandom & 32'h0000_ffff;
            wr_strb = 4'(st);
            wr(alarm_log_pkg::OFF_MASK, 32'(nm));
            if (st[0]) mask_m = (mask_m & 32'h0000_ff00) | (nm & 32'h0000_00ff);
            if (st[1]) mask_m = (mask_m & 32'h0000_00ff) | (nm & 32'h0000_ff00);
            rd_reg(alarm_log_pkg::OFF_MASK);
            check("mask strobes", rd, mask_m);
            fire(16'($urandom));
            check_log();
        end
        wr_strb = 4'hf;
        $display("test random events done");
        wr(alarm_log_pkg::OFF_CTRL, 32'h0000_0003);
        log_m = 0;
        check_log();
        rd_reg(alarm_log_pkg::OFF_CTRL);
        check("ctrl clear self", rd, 32'h0000_0002);
        $display("test host clear done");
        wr(alarm_log_pkg::OFF_IRQ_CLEAR, 32'h0000_0007);
        wr(alarm_log_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
        mask_m = 2;
        wr(alarm_log_pkg::OFF_MASK, 32'h0000_0002);
        fire(16'h0002);
        check("irq masked", irq_out, 0);
        fire(16'h0001);
        check("irq raised", irq_out, 1);
        wr(alarm_log_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
        repeat (2) @(posedge sys_clk_in);
        check("irq cleared", irq_out, 0);
        check_log();
        $display("test interrupt done");
        mask_m = 0;
        wr(alarm_log_pkg::OFF_MASK, 32'h0000_0000);
        fire(16'h8001);
        pad.pick(0);
        pad.press(0);
        @(posedge sys_clk_in);
        check("window open", confirm_open_out, 1);
        repeat (WIN / 2) @(posedge sys_clk_in);
        pad.press(0);
        log_m = 0;
        check_log();
        fire(16'h0004);
        pad.press(0);
        repeat (WIN + 5) @(posedge sys_clk_in);
        check("window shut", confirm_open_out, 0);
        check_log();
        rd_reg(alarm_log_pkg::OFF_IRQ_STATUS);
        check("expired", rd[alarm_log_pkg::IRQ_EXPIRED_BIT], 1);
        check("irq status", rd, 32'h0000_0007);
        $display("test keypad clear done");
        pad.pick(1);
        pad.press(0);
        @(posedge sys_clk_in);
        check("edit on", edit_active_out, 1);
        check("cursor start", cursor_out, 0);
        repeat (3) pad.press(3);
        pad.press(2);
        @(posedge sys_clk_in);
        check("cursor moved", cursor_out, 3);
        pad.press(0);
        @(posedge sys_clk_in);
        check("edit off", edit_active_out, 0);
        mask_m = 8;
        rd_reg(alarm_log_pkg::OFF_MASK);
        check("mask stored", rd, mask_m);
        fire(16'h0018);
        check_log();
        $display("test mask edit done");
        pad.pick(2);
        for (int e = 0; e < 2; e++) begin
            pad.press(0);
            @(posedge sys_clk_in);
            check("list on", list_active_out, 1);
            idx = list_index_out;
            pad.press(3);
            @(posedge sys_clk_in);
            check("scrolled", list_index_out, idx + 4'h1);
            pad.press(2);
            @(posedge sys_clk_in);
            check("scrolled back", list_index_out, idx);
            pad.press(e);
            @(posedge sys_clk_in);
            check("list off", list_active_out, 0);
        end
        $display("test event list done");
        rd_reg(8'h40);
        check("unmapped", resp, alarm_log_pkg::RESP_SLVERR);
        $display("test unmapped done");
        report_and_stop();
    end
endmodule // alarm_event_log_test
`default_nettype wire
